// >>> include/afc_pkg.sv
// =====================================================
// fifo controller constants and types
package afc_pkg;
  // clock and geometry
  localparam int CLK_NS = 20;
  localparam int DEPTH = 512;
  localparam int WORD_W = 9;
  localparam int NDEV = 2;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W = 10;
  // =====================================================
  // pin timing of the buffer, in ns
  localparam int T_STB_PW_NS = 20;
  localparam int T_STB_REC_NS = 10;
  localparam int T_ACCESS_NS = 20;
  localparam int T_FLAG_NS = 20;
  localparam int T_MR_PW_NS = 20;
  localparam int T_STB_PRE_NS = 20;
  localparam int T_MR_REC_NS = 10;
  localparam int T_RT_PW_NS = 20;
  localparam int T_RT_REC_NS = 10;
  // least times round up, never below one cycle
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam logic [7:0] MR_LOW_CYC =
    8'(ns2cyc(T_MR_PW_NS) + ns2cyc(T_STB_PRE_NS));
  localparam logic [7:0] MR_REC_CYC = 8'(ns2cyc(T_MR_REC_NS));
  localparam logic [7:0] WR_LOW_CYC = 8'(ns2cyc(T_STB_PW_NS));
  localparam logic [7:0] STB_REC_CYC = 8'(ns2cyc(T_STB_REC_NS));
  localparam logic [7:0] RD_LOW_CYC =
    8'(ns2cyc(T_ACCESS_NS) + SYNC_STAGES + 1);
  localparam logic [7:0] RT_LOW_CYC = 8'(ns2cyc(T_RT_PW_NS));
  localparam logic [7:0] RT_REC_CYC = 8'(ns2cyc(T_RT_REC_NS));
  localparam logic [7:0] SETTLE_CYC =
    8'(ns2cyc(T_FLAG_NS) + SYNC_STAGES + 1);
  // =====================================================
  // register map, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TX = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RX = 8'h10;
  localparam logic [7:0] OFS_WRCNT = 8'h14;
  // field positions
  localparam int CTRL_DEPTH_BIT = 0;
  localparam int CTRL_LEAD_BIT = 1;
  localparam int CMD_POP_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  localparam int CMD_REPLAY_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam int ST_HALF_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_RXVALID_BIT = 5;
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 9'h000;
  // =====================================================
  typedef enum logic [3:0] {
    ST_POR, ST_IDLE, ST_CLR_LOW, ST_CLR_REC, ST_WR_LOW, ST_WR_REC,
    ST_RD_LOW, ST_RD_REC, ST_RT_LOW, ST_RT_REC, ST_SETTLE
  } afc_state_t;
  // pins arriving from the buffer, synchronised as one bundle
  typedef struct packed {
    logic [NDEV-1:0] full_n;
    logic [NDEV-1:0] empty_n;
    logic half_n;
    logic [WORD_W-1:0] word;
  } afc_pins_in_t;
endpackage

// >>> rtl/afc_sync.sv
`timescale 1ns/1ps
// =====================================================
// two-flop synchroniser, one chain per bit
module afc_sync #(
  parameter int W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  genvar i;
  // first stage is read by the second stage only
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg[i] <= 1'b1;
          q[i] <= 1'b1;
        end else begin
          meta_reg[i] <= d[i];
          q[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule

// >>> rtl/afc_timer.sv
`timescale 1ns/1ps
// =====================================================
// down counter that times each pin phase
module afc_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [7:0] load_val,
  output logic done
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  // a load wins over counting; stops at zero
  assign count_next = load ? load_val :
    (count_reg == 8'h00) ? 8'h00 : count_reg - 8'h01;
  assign done = (count_reg == 8'h00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule

// >>> rtl/afc_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - controller clears buffer after power up; strobes high around clear.
// - controller keeps both strobes high during and after replay.
// - replay only when writes since clear do not exceed depth.
// - standalone: token input tied low, lead select tied high.
// - depth chain formed during clear; lead device has select low. Straps here follow a ctrl write one cycle later, clear or not.
// - depth chain: composite full and empty formed by or-ing flags.
// - never read while empty flag low, never write while full.
module afc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic push_pulse,
  output logic pop_pulse,
  output logic [8:0] input_word,
  output logic global_clear_n,
  output logic replay_n,
  output logic chain_token_in_o,
  output logic chain_token_in_oe,
  output logic lead_device_sel,
  input wire logic [8:0] output_word,
  input wire logic [1:0] empty_flag_n,
  input wire logic [1:0] full_flag_n,
  input wire logic half_flag_n
);
  // =====================================================
  // declarations
  afc_pkg::afc_state_t state_reg, state_next;
  afc_pkg::afc_pins_in_t pin_raw, pin_s;
  logic [7:0] tmr_val;
  logic tmr_done;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic push_reg, pop_reg, clear_n_reg, replay_n_reg;
  logic [8:0] tx_word_reg, rx_word_reg;
  logic tie_o_reg, tie_oe_reg, lead_sel_reg;
  logic depth_mode_reg, lead_first_reg;
  logic refused_reg, rx_valid_reg;
  logic [afc_pkg::CNT_W-1:0] wr_count_reg;

  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] o);
    return a == o;
  endfunction

  // =====================================================
  // pin inputs: every buffer pin passes two flops first
  assign pin_raw = {full_flag_n, empty_flag_n, half_flag_n, output_word};
  afc_sync #(.W($bits(afc_pkg::afc_pins_in_t))) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_raw),
    .q(pin_s)
  );

  // composite flags; only device 0 counts when standalone
  // or-ing chain flags
  wire comp_full_n = depth_mode_reg ? |pin_s.full_n : pin_s.full_n[0];
  wire comp_empty_n = depth_mode_reg ? |pin_s.empty_n : pin_s.empty_n[0];
  wire is_full = !comp_full_n;
  wire is_empty = !comp_empty_n;
  wire is_half = !depth_mode_reg && !pin_s.half_n;

  // =====================================================
  // apb decode: setup cycle arms a one-cycle access phase
  wire apb_setup = psel && !penable;
  wire apb_done = psel && penable && pready_reg;
  wire wr_en = apb_done && pwrite;
  wire rd_en = apb_done && !pwrite;
  wire hit_ctrl = reg_hit(paddr, afc_pkg::OFS_CTRL);
  wire hit_tx = reg_hit(paddr, afc_pkg::OFS_TX);
  wire hit_cmd = reg_hit(paddr, afc_pkg::OFS_CMD);
  wire hit_st = reg_hit(paddr, afc_pkg::OFS_STATUS);
  wire hit_rx = reg_hit(paddr, afc_pkg::OFS_RX);
  wire hit_cnt = reg_hit(paddr, afc_pkg::OFS_WRCNT);
  wire mapped = hit_ctrl | hit_tx | hit_cmd | hit_st | hit_rx | hit_cnt;

  // status word shows the controller and buffer state
  wire [5:0] status_word = {rx_valid_reg, refused_reg, is_half,
                            is_full, is_empty, state_reg != afc_pkg::ST_IDLE};
  wire [31:0] rd_word =
    hit_ctrl ? {30'h0, lead_first_reg, depth_mode_reg} :
    hit_tx ? {23'h0, tx_word_reg} :
    hit_st ? {26'h0, status_word} :
    hit_rx ? {23'h0, rx_word_reg} :
    hit_cnt ? {22'h0, wr_count_reg} : 32'h0;

  // =====================================================
  // command acceptance; busy or unsafe requests are refused
  wire idle = (state_reg == afc_pkg::ST_IDLE);
  wire tx_req = wr_en && hit_tx;
  wire cmd_req = wr_en && hit_cmd;
  wire want_pop = cmd_req && pwdata[afc_pkg::CMD_POP_BIT];
  wire want_clr = cmd_req && pwdata[afc_pkg::CMD_CLEAR_BIT];
  wire want_rt = cmd_req && pwdata[afc_pkg::CMD_REPLAY_BIT];
  wire go_clr = want_clr && idle;
  wire rt_ok = wr_count_reg <= afc_pkg::CNT_W'(afc_pkg::DEPTH);
  wire go_rt = want_rt && !want_clr && idle && !depth_mode_reg && rt_ok;
  wire go_push = tx_req && idle && !is_full;
  wire go_pop = want_pop && !want_clr && !want_rt && idle && !is_empty;
  wire any_req = tx_req || want_pop || want_clr || want_rt;
  wire refuse = any_req && !(go_clr || go_rt || go_push || go_pop);

  // =====================================================
  // sequencer: each pin phase lasts a timed number of cycles
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      afc_pkg::ST_POR: state_next = afc_pkg::ST_CLR_LOW;
      afc_pkg::ST_IDLE: begin
        if (go_clr) state_next = afc_pkg::ST_CLR_LOW;
        else if (go_rt) state_next = afc_pkg::ST_RT_LOW;
        else if (go_push) state_next = afc_pkg::ST_WR_LOW;
        else if (go_pop) state_next = afc_pkg::ST_RD_LOW;
      end
      afc_pkg::ST_CLR_LOW: if (tmr_done) state_next = afc_pkg::ST_CLR_REC;
      afc_pkg::ST_WR_LOW: if (tmr_done) state_next = afc_pkg::ST_WR_REC;
      afc_pkg::ST_RD_LOW: if (tmr_done) state_next = afc_pkg::ST_RD_REC;
      afc_pkg::ST_RT_LOW: if (tmr_done) state_next = afc_pkg::ST_RT_REC;
      afc_pkg::ST_CLR_REC, afc_pkg::ST_WR_REC,
      afc_pkg::ST_RD_REC, afc_pkg::ST_RT_REC: begin
        if (tmr_done) state_next = afc_pkg::ST_SETTLE;
      end
      afc_pkg::ST_SETTLE: if (tmr_done) state_next = afc_pkg::ST_IDLE;
      default: state_next = afc_pkg::ST_IDLE;
    endcase
  end

  // phase length of the state being entered, minus one
  always_comb begin
    case (state_next)
      afc_pkg::ST_CLR_LOW: tmr_val = afc_pkg::MR_LOW_CYC - 8'h01;
      afc_pkg::ST_CLR_REC: tmr_val = afc_pkg::MR_REC_CYC - 8'h01;
      afc_pkg::ST_WR_LOW: tmr_val = afc_pkg::WR_LOW_CYC - 8'h01;
      afc_pkg::ST_RD_LOW: tmr_val = afc_pkg::RD_LOW_CYC - 8'h01;
      afc_pkg::ST_RT_LOW: tmr_val = afc_pkg::RT_LOW_CYC - 8'h01;
      afc_pkg::ST_RT_REC: tmr_val = afc_pkg::RT_REC_CYC - 8'h01;
      afc_pkg::ST_SETTLE: tmr_val = afc_pkg::SETTLE_CYC - 8'h01;
      default: tmr_val = afc_pkg::STB_REC_CYC - 8'h01;
    endcase
  end

  afc_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(state_next != state_reg),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // pin levels follow the next state so they leave flops aligned
  // strobes high across clear
  wire clear_n_next = (state_next != afc_pkg::ST_CLR_LOW);
  wire replay_n_next = (state_next != afc_pkg::ST_RT_LOW);
  wire push_next = (state_next != afc_pkg::ST_WR_LOW);
  wire pop_next = (state_next != afc_pkg::ST_RD_LOW);
  // sample word late in pop low
  wire capture = (state_reg == afc_pkg::ST_RD_LOW) && tmr_done;
  wire cnt_max = (wr_count_reg == afc_pkg::CNT_W'(afc_pkg::DEPTH + 1));

  // =====================================================
  // state, pins and data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= afc_pkg::ST_POR;
      push_reg <= 1'b1;
      pop_reg <= 1'b1;
      clear_n_reg <= 1'b1;
      replay_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      push_reg <= push_next;
      pop_reg <= pop_next;
      clear_n_reg <= clear_n_next;
      replay_n_reg <= replay_n_next;
    end
  end

  // word held after push rises, so data hold is met for free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_word_reg <= afc_pkg::WORD_RST;
      rx_word_reg <= afc_pkg::WORD_RST;
    end else begin
      if (go_push) tx_word_reg <= pwdata[8:0];
      if (capture) rx_word_reg <= pin_s.word;
    end
  end

  // writes since the last clear, saturating one past depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_count_reg <= '0;
    end else if (state_reg == afc_pkg::ST_CLR_LOW) begin
      wr_count_reg <= '0;
    end else if (go_push && !cnt_max) begin
      wr_count_reg <= wr_count_reg + afc_pkg::CNT_W'(1);
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
    end else begin
      refused_reg <= refuse || (refused_reg && !(rd_en && hit_st));
      rx_valid_reg <= capture || (rx_valid_reg && !(rd_en && hit_rx));
    end
  end

  // mode bits; a chain change takes hold at once, the straps follow one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lead_first_reg, depth_mode_reg} <= afc_pkg::CTRL_RST;
    end else if (wr_en && hit_ctrl) begin
      depth_mode_reg <= pwdata[afc_pkg::CTRL_DEPTH_BIT];
      lead_first_reg <= pwdata[afc_pkg::CTRL_LEAD_BIT];
    end
  end

  // strap pins; token input released in chain so the ring drives it
  // standalone ties
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tie_o_reg <= 1'b0;
      tie_oe_reg <= 1'b1;
      lead_sel_reg <= 1'b1;
    end else begin
      tie_o_reg <= 1'b0;
      tie_oe_reg <= !depth_mode_reg;
      lead_sel_reg <= !(depth_mode_reg && lead_first_reg);
    end
  end

  // apb slave: fixed one-cycle access, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup && !mapped;
      prdata_reg <= (apb_setup && !pwrite) ? rd_word : 32'h0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign push_pulse = push_reg;
  assign pop_pulse = pop_reg;
  assign input_word = tx_word_reg;
  assign global_clear_n = clear_n_reg;
  assign replay_n = replay_n_reg;
  assign chain_token_in_o = tie_o_reg;
  assign chain_token_in_oe = tie_oe_reg;
  assign lead_device_sel = lead_sel_reg;
  // =====================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_clear_quiet: assert property (
    !global_clear_n |-> push_pulse && pop_pulse)
    else $error("strobe low during clear");
  chk_clear_recover: assert property (
    $rose(global_clear_n) |-> (push_pulse && pop_pulse)[*2])
    else $error("strobe low right after clear");
  chk_replay_hold: assert property (
    $rose(replay_n) |-> (push_pulse && pop_pulse)[*2])
    else $error("strobe low around replay");
  chk_replay_gate: assert property (
    $fell(replay_n) |-> !depth_mode_reg && wr_count_reg <= 10'h200)
    else $error("replay issued when not allowed");
  chk_push_not_full: assert property (
    $fell(push_pulse) |-> !$past(is_full))
    else $error("write started while full");
  chk_pop_not_empty: assert property (
    $fell(pop_pulse) |-> !$past(is_empty) ##4 pop_pulse)
    else $error("bad read strobe");
  chk_chain_tie: assert property (
    !depth_mode_reg ##1 !depth_mode_reg |->
      chain_token_in_oe && !chain_token_in_o && lead_device_sel)
    else $error("standalone straps wrong");
  chk_push_cycle: assert property (
    $fell(push_pulse) |-> ##1 push_pulse [*5] ##1 idle)
    else $error("write cycle timing wrong");
  chk_half_masked: assert property (
    depth_mode_reg |-> !status_word[afc_pkg::ST_HALF_BIT])
    else $error("half flag shown in chain mode");
  chk_refuse_busy: assert property (
    tx_req && !idle |=> refused_reg && $stable(input_word))
    else $error("busy write not refused");

  cov_push: cover property ($fell(push_pulse) ##6 idle);
  cov_pop: cover property (capture ##[1:8] rd_en && hit_rx);
  cov_replay: cover property ($rose(replay_n));
  cov_refuse: cover property (refuse);
endmodule

// >>> tb/afc_fifo_model.sv
`timescale 1ns/1ps
// =====================================================
// behavioural 512x9 strobe buffer, standalone mode only
module afc_fifo_model (
  input wire logic push_pulse,
  input wire logic pop_pulse,
  input wire logic [8:0] input_word,
  input wire logic global_clear_n,
  input wire logic replay_n,
  output logic [8:0] output_word,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic half_flag_n
);
  logic [8:0] mem [512];
  // started and finished counts, one lap wider; garbage until cleared
  logic [9:0] ws = 10'h0A3, wp = 10'h0A3, rs = 10'h011, rp = 10'h011;
  logic wr_ok = 1'b0, rd_ok = 1'b0;
  logic [8:0] last = 9'h000;
  // clear restarts both pointers, replay only the read side
  always @(negedge global_clear_n or negedge replay_n) begin
    rs = 10'h000;
    rp = 10'h000;
    if (!global_clear_n) begin
      ws = 10'h000;
      wp = 10'h000;
    end
  end
  // write counted at the fall, stored at the rise
  always @(negedge push_pulse) begin
    wr_ok = (ws - rp) != 10'h200;
    if (wr_ok) ws = ws + 10'h001;
  end
  always @(posedge push_pulse) begin
    if (wr_ok) begin
      mem[wp[8:0]] = input_word;
      wp = wp + 10'h001;
    end
    wr_ok = 1'b0;
  end
  // read only when not empty, addresses wrap
  always @(negedge pop_pulse) begin
    rd_ok = (wp - rs) != 10'h000;
    if (rd_ok) begin
      last = mem[rs[8:0]];
      rs = rs + 10'h001;
    end
  end
  always @(posedge pop_pulse) begin
    if (rd_ok) rp = rp + 10'h001;
    rd_ok = 1'b0;
  end
  // flags settle half a cycle after the strobe edge
  assign #10 empty_flag_n = (wp - rs) != 10'h000;
  assign #10 full_flag_n = (ws - rp) != 10'h200;
  assign #10 half_flag_n = (ws - rp) <= 10'h100;
  // released lines show the inverse, never a kind last value
  assign #15 output_word = (!pop_pulse && rd_ok) ? last : ~last;
endmodule

// >>> tb/tb_afc_ctrl.sv
`timescale 1ns/1ps
// =====================================================
// bench for the strobe buffer controller
module tb_afc_ctrl;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic pready, pslverr, push_pulse, pop_pulse, global_clear_n, replay_n;
  logic tok_o, tok_oe, lead_sel, m_empty_n, m_full_n, m_half_n;
  logic [8:0] input_word, output_word;
  int failures = 0, check_count = 0, i;
  logic [31:0] seed = 32'h62;
  logic [32:0] exp_q[$], msk_q[$], we, wm;
  string nam_q[$], wn;
  logic [8:0] words[$], keep[$];
  // the second chain device stays in standby, its flags idle high
  afc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .push_pulse(push_pulse), .pop_pulse(pop_pulse),
    .input_word(input_word), .global_clear_n(global_clear_n),
    .replay_n(replay_n), .chain_token_in_o(tok_o),
    .chain_token_in_oe(tok_oe), .lead_device_sel(lead_sel),
    .output_word(output_word), .empty_flag_n({1'b1, m_empty_n}),
    .full_flag_n({1'b1, m_full_n}), .half_flag_n(m_half_n));
  afc_fifo_model u_dev (.push_pulse(push_pulse), .pop_pulse(pop_pulse),
    .input_word(input_word), .global_clear_n(global_clear_n),
    .replay_n(replay_n), .output_word(output_word),
    .empty_flag_n(m_empty_n), .full_flag_n(m_full_n),
    .half_flag_n(m_half_n));
  initial begin
    forever #10 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // one transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle count assumed; only the watchdog ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // note the expected {pslverr, prdata} then read
  task automatic rdchk(string s, logic [7:0] a, logic [32:0] e,
                       logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    nam_q.push_back(s);
    apb(1'b0, a, 32'h0);
  endtask
  // polling clears the refused bit, so refusals are read before this
  task automatic idle();
    int n;
    n = 0;
    do begin
      rdchk("poll", afc_pkg::OFS_STATUS, 33'h0, 33'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 60);
    if (n >= 60) begin
      failures++;
      $display("[FAIL] busy expected 0 seen 1");
    end
  endtask
  task automatic push(logic [8:0] w);
    apb(1'b1, afc_pkg::OFS_TX, {23'h0, w});
    words.push_back(w);
    idle();
  endtask
  task automatic pop();
    apb(1'b1, afc_pkg::OFS_CMD, 32'h1);
    idle();
    rdchk("rx word", afc_pkg::OFS_RX, {24'h0, words.pop_front()}, 33'h1FF);
  endtask
  task automatic push_rnd(int k);
    repeat (k) begin
      r = rnd();
      push(r[8:0]);
    end
  endtask
  // expected {half, full, empty} in status bits 3:1
  task automatic status(string s, logic [2:0] hfe);
    rdchk(s, afc_pkg::OFS_STATUS, {29'h0, hfe, 1'b0}, 33'h0E);
  endtask
  task automatic refused(string s);
    rdchk(s, afc_pkg::OFS_STATUS, 33'h10, 33'h10);
  endtask
  task automatic pin(string s, logic e, logic g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // =====================================================
  // watcher: every completed read takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      we = exp_q.pop_front();
      wm = msk_q.pop_front();
      wn = nam_q.pop_front();
      if (wm != 33'h0) begin
        check_count++;
        if (({pslverr, prdata} & wm) !== (we & wm)) begin
          failures++;
          $display("[FAIL] %s expected %h seen %h", wn, we & wm,
                   {pslverr, prdata} & wm);
        end
      end
    end
  end
  // strobes never start against a blocking flag
  always @(negedge pop_pulse or negedge push_pulse) begin
    if (!pop_pulse && m_empty_n !== 1'b1 || !push_pulse && m_full_n !== 1'b1)
    begin
      failures++;
      $display("[FAIL] strobe expected blocked seen started");
    end
  end
  // strobes idle around clear release and replay
  // the clear pin leaving unknown under reset is not a real release
  always @(posedge global_clear_n or negedge replay_n) begin
    if (presetn) begin
      pin("idle strobes", 1'b1, push_pulse & pop_pulse);
    end
  end
  // the tests need about 16k cycles; allow twice that and a margin
  initial begin
    #800000;
    failures++;
    $display("watchdog expired");
    conclude();
  end
  // =====================================================
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    status("after clear", 3'b001);
    rdchk("ctrl reset", afc_pkg::OFS_CTRL, 33'h0, 33'h3);
    rdchk("wrcnt reset", afc_pkg::OFS_WRCNT, 33'h0, 33'h3FF);
    rdchk("unmapped", 8'h18, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    pin("lead sel", 1'b1, lead_sel);
    pin("token oe", 1'b1, tok_oe);
    $display("test reset done");
    apb(1'b1, afc_pkg::OFS_CMD, 32'h1);
    refused("empty pop");
    push_rnd(4);
    rdchk("tx back", afc_pkg::OFS_TX, {24'h0, words[3]}, 33'h1FF);
    status("four held", 3'b000);
    repeat (4) pop();
    status("drained", 3'b001);
    // a second write while the first is still running is refused
    apb(1'b1, afc_pkg::OFS_TX, 32'h0C3);
    apb(1'b1, afc_pkg::OFS_TX, 32'h13C);
    refused("busy push");
    words.push_back(9'h0C3);
    idle();
    pop();
    $display("test order done");
    push_rnd(256);
    status("half", 3'b000);
    push_rnd(1);
    status("half plus one", 3'b100);
    pop();
    status("back to half", 3'b000);
    push_rnd(256);
    status("full", 3'b110);
    apb(1'b1, afc_pkg::OFS_TX, 32'h1A5);
    refused("full push");
    pop();
    status("one free", 3'b100);
    for (i = 0; i < 511; i++) pop();
    push_rnd(3);
    repeat (3) pop();
    status("wrapped empty", 3'b001);
    $display("test flags done");
    // replay used with fewer writes than the depth
    apb(1'b1, afc_pkg::OFS_CMD, 32'h2);
    idle();
    words.delete();
    push_rnd(3);
    keep = words;
    pop();
    apb(1'b1, afc_pkg::OFS_CMD, 32'h4);
    idle();
    words = keep;
    push_rnd(1);
    status("replayed", 3'b000);
    repeat (4) pop();
    status("replay drained", 3'b001);
    rdchk("wrcnt", afc_pkg::OFS_WRCNT, 33'h4, 33'h3FF);
    $display("test replay done");
    apb(1'b1, afc_pkg::OFS_CTRL, 32'h3);
    apb(1'b1, afc_pkg::OFS_CMD, 32'h2);
    idle();
    pin("lead chain", 1'b0, lead_sel);
    pin("oe chain", 1'b0, tok_oe);
    apb(1'b1, afc_pkg::OFS_CMD, 32'h4);
    refused("depth replay");
    apb(1'b1, afc_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, afc_pkg::OFS_CMD, 32'h2);
    idle();
    pin("lead back", 1'b1, lead_sel);
    $display("test depth done");
    conclude();
  end
endmodule
